// file: include/xcc_regs.svh
/*
 * Register indices, field positions, reset values and timing figures
 * for the crystal oscillator and clock output control block.
 * Assumes a 16-bit register map reached over a 32-bit bus, one register
 * per aligned word (byte address = 4 x index).
 */
`ifndef XCC_REGS_SVH
`define XCC_REGS_SVH

// register indices
`define XCC_IDX_SYS_STATE     16'h400D
`define XCC_IDX_IRQ_FLAGS     16'h4014
`define XCC_IDX_IRQ_MASKS     16'h401C
`define XCC_IDX_CLOCK_OUTPUT_PIN_CTRL   16'h4090
`define XCC_IDX_OSC_CTRL      16'h4091

// field positions
`define XCC_B_VERIFIED        7
`define XCC_B_START_FAIL      7
`define XCC_B_TAMPER          6
`define XCC_B_OUT_EN          15
`define XCC_B_OUT_OD          13
`define XCC_F_ON_SLOT_HI      10
`define XCC_F_ON_SLOT_LO      8
`define XCC_F_SLP_SLOT_HI     6
`define XCC_F_SLP_SLOT_LO     4
`define XCC_B_INHIBIT         15
`define XCC_B_OSC_EN          13
`define XCC_B_BACKUP_EN       12

// reset values
`define XCC_RST_OUT_EN        1'b0
`define XCC_RST_OUT_OD        1'b0
`define XCC_RST_SLOT          3'h0
`define XCC_RST_INHIBIT       1'b0
`define XCC_RST_OSC_EN        1'b0
`define XCC_RST_BACKUP_EN     1'b1
`define XCC_RST_MASK          1'b1

// slot codes
`define XCC_SLOT_MIN          3'h1
`define XCC_SLOT_MAX          3'h5
`define XCC_SLP_SLOT_BASE     3'h6

// timing
`define XCC_CLK_HZ            10_000_000
`define XCC_START_FAIL_S      24
`define XCC_RESET_TO_S        32

`endif

// file: include/xcc_pkg.sv
/*
 * Types shared by the crystal/clock output control design.
 * Assumes the power state sequencer drives the power state codes below.
 */
package xcc_pkg;
  typedef enum logic [1:0] {
    XCC_PS_OFF    = 2'b00,
    XCC_PS_ON     = 2'b01,
    XCC_PS_SLEEP  = 2'b10,
    XCC_PS_BACKUP = 2'b11
  } xcc_pwr_t;

  typedef enum logic [2:0] {
    XCC_XS_IDLE  = 3'b000,
    XCC_XS_START = 3'b001,
    XCC_XS_RUN   = 3'b010,
    XCC_XS_FAIL  = 3'b011,
    XCC_XS_STOP  = 3'b100
  } xcc_xstate_t;
endpackage

// file: rtl/xcc_clk_switch.sv
/*
 * Glitch-free clock output source switch and pin driver.
 * Assumes both source levels are sampled synchronously to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module xcc_clk_switch (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sel_xtal_i,
  input  wire logic xtal_lvl_i,
  input  wire logic rc_lvl_i,
  input  wire logic en_i,
  input  wire logic od_i,
  output logic      pin_o,
  output logic      oe_o
);
  logic src_q;
  logic lvl;

  assign lvl = src_q ? xtal_lvl_i : rc_lvl_i;

  // change source only while both clocks are low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= 1'b0;
    end else if (src_q != sel_xtal_i && !xtal_lvl_i && !rc_lvl_i) begin
      src_q <= sel_xtal_i;
    end
  end

  // open drain pulls low only, else drive both ways
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      oe_o  <= 1'b0;
    end else begin
      pin_o <= en_i & lvl & ~od_i;
      oe_o  <= od_i ? (en_i & ~lvl) : en_i;
    end
  end

  property p_src_stable;
    @(posedge clk_i) disable iff (rst_i)
      (xtal_lvl_i || rc_lvl_i) |=> $stable(src_q);
  endproperty
  a_src_stable: assert property (p_src_stable)
    else $error("source changed while a clock was high");
endmodule

`default_nettype wire

// file: rtl/xcc_top.sv
/*
 * Crystal oscillator supervision, clock output control, crystal event
 * flags and primary interrupt, with a classic Wishbone register slave.
 * Assumes the power state, timeslot strobes, user key state, crystal
 * running indication and both clock levels arrive synchronous to clk_i.
 */
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "xcc_regs.svh"

module xcc_top #(
  parameter int START_FAIL_CYC = `XCC_START_FAIL_S * `XCC_CLK_HZ,
  parameter int RESET_TO_CYC   = `XCC_RESET_TO_S * `XCC_CLK_HZ
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [31:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire xcc_pkg::xcc_pwr_t pwr_state_i,
  input  wire logic             seq_up_i,
  input  wire logic             seq_sleep_i,
  input  wire logic [2:0]       timeslot_i,
  input  wire logic             user_key_unlocked_i,
  input  wire logic             cfg_load_i,
  input  wire logic             cfg_osc_enable_i,
  input  wire logic             xtal_running_i,
  input  wire logic             xtal_clk_i,
  input  wire logic             rc_clk_i,
  output logic                  osc_run_o,
  output logic                  rtc_clk_en_o,
  output logic                  on_hold_o,
  output logic                  sys_reset_req_o,
  output logic                  rtc_osc_primary_irq_o,
  output logic                  clock_output_pin_o,
  output logic                  clock_output_oe_o
);
  import xcc_pkg::*;

  localparam int CW = $clog2(RESET_TO_CYC + 1);

  // counter is sized for the reset timeout and saturates there
  if (START_FAIL_CYC < 1 || RESET_TO_CYC < START_FAIL_CYC) begin : g_bad_timeouts
    $error("timeouts need one cycle at least and reset no sooner than failure");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    merge = old;
    if (sel[0]) begin
      merge[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge[15:8] = dat[15:8];
    end
  endfunction

  function automatic logic slot_valid(input logic [2:0] code);
    slot_valid = code >= `XCC_SLOT_MIN && code <= `XCC_SLOT_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic              out_en_q;
  logic              out_od_q;
  logic [2:0]        on_slot_q;
  logic [2:0]        slp_slot_q;
  logic              inhibit_q;
  logic              osc_en_q;
  logic              backup_en_q;
  logic              start_flag_q;
  logic              tamper_flag_q;
  logic              start_mask_q;
  xcc_xstate_t       xst_q;
  logic [CW-1:0]     cnt_q;
  logic              reset_done_q;
  logic              out_live_q;

  logic              acc;
  logic              wr;
  logic [15:0]       idx;
  logic [15:0]       wd_clk;
  logic [15:0]       wd_osc;
  logic [15:0]       wd_msk;
  logic              verified;
  logic              fail_ev;
  logic              tamper_ev;
  logic              seq_on_hit;
  logic              seq_off_hit;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = acc & wb_we_i;
  assign idx = wb_adr_i[17:2];
  assign wd_clk = merge({out_en_q, 1'b0, out_od_q, 2'b00, on_slot_q,
                         1'b0, slp_slot_q, 4'h0}, wb_dat_i, wb_sel_i);
  assign wd_osc = merge({inhibit_q, 1'b0, osc_en_q, backup_en_q, 12'h000},
                        wb_dat_i, wb_sel_i);
  assign wd_msk = merge({8'h00, start_mask_q, 7'h00}, wb_dat_i, wb_sel_i);
  assign verified = xst_q == XCC_XS_RUN;

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads zero

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      unique case (idx)
        `XCC_IDX_SYS_STATE:
          wb_dat_o <= {24'h00_0000, verified, 7'h00};
        `XCC_IDX_IRQ_FLAGS:
          wb_dat_o <= {24'h00_0000, start_flag_q, tamper_flag_q, 6'h00};
        `XCC_IDX_IRQ_MASKS:
          wb_dat_o <= {24'h00_0000, start_mask_q, 7'h00};
        `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL:
          wb_dat_o <= {16'h0000, out_en_q, 1'b0, out_od_q, 2'b00,
                       on_slot_q, 1'b0, slp_slot_q, 4'h0};
        `XCC_IDX_OSC_CTRL:
          wb_dat_o <= {16'h0000, inhibit_q, 1'b0, osc_en_q, backup_en_q,
                       12'h000};
        default:
          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock output control register

  assign seq_on_hit  = seq_up_i && slot_valid(on_slot_q) &&
                       timeslot_i == on_slot_q;
  assign seq_off_hit = seq_sleep_i && slot_valid(slp_slot_q) &&
                       timeslot_i == 3'(`XCC_SLP_SLOT_BASE - slp_slot_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_en_q <= `XCC_RST_OUT_EN;
    end else if (seq_on_hit) begin
      out_en_q <= 1'b1;
    end else if (seq_off_hit) begin
      out_en_q <= 1'b0;
    end else if (wr && idx == `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL && user_key_unlocked_i) begin
      out_en_q <= wd_clk[`XCC_B_OUT_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_od_q   <= `XCC_RST_OUT_OD;
      on_slot_q  <= `XCC_RST_SLOT;
      slp_slot_q <= `XCC_RST_SLOT;
    end else if (wr && idx == `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL) begin
      out_od_q   <= wd_clk[`XCC_B_OUT_OD];
      on_slot_q  <= wd_clk[`XCC_F_ON_SLOT_HI:`XCC_F_ON_SLOT_LO];
      slp_slot_q <= wd_clk[`XCC_F_SLP_SLOT_HI:`XCC_F_SLP_SLOT_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator control register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit_q   <= `XCC_RST_INHIBIT;
      backup_en_q <= `XCC_RST_BACKUP_EN;
    end else if (wr && idx == `XCC_IDX_OSC_CTRL) begin
      inhibit_q   <= wd_osc[`XCC_B_INHIBIT];
      backup_en_q <= wd_osc[`XCC_B_BACKUP_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_q <= `XCC_RST_OSC_EN;
    end else if (cfg_load_i) begin
      osc_en_q <= cfg_osc_enable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_mask_q <= `XCC_RST_MASK;
    end else if (wr && idx == `XCC_IDX_IRQ_MASKS) begin
      start_mask_q <= wd_msk[`XCC_B_START_FAIL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator run and rtc clocking per power state

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_run_o    <= 1'b0;
      rtc_clk_en_o <= 1'b0;
    end else if (pwr_state_i == XCC_PS_BACKUP) begin
      osc_run_o    <= osc_en_q & backup_en_q;
      rtc_clk_en_o <= osc_en_q & backup_en_q;
    end else begin
      osc_run_o    <= osc_en_q;
      rtc_clk_en_o <= osc_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crystal supervision

  assign fail_ev   = xst_q == XCC_XS_START && osc_run_o &&
                     !xtal_running_i && cnt_q >= CW'(START_FAIL_CYC);
  assign tamper_ev = osc_run_o &&
                     ((xst_q == XCC_XS_RUN && !xtal_running_i) ||
                      (xst_q == XCC_XS_STOP && xtal_running_i));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xst_q <= XCC_XS_IDLE;
    end else if (!osc_run_o) begin
      xst_q <= XCC_XS_IDLE;
    end else begin
      unique case (xst_q)
        XCC_XS_IDLE:  xst_q <= XCC_XS_START;
        XCC_XS_START: begin
          if (xtal_running_i) begin
            xst_q <= XCC_XS_RUN;
          end else if (fail_ev) begin
            xst_q <= XCC_XS_FAIL;
          end
        end
        XCC_XS_FAIL: begin
          if (xtal_running_i) begin
            xst_q <= XCC_XS_RUN;
          end
        end
        XCC_XS_RUN: begin
          if (!xtal_running_i) begin
            xst_q <= XCC_XS_STOP;
          end
        end
        XCC_XS_STOP: begin
          if (xtal_running_i) begin
            xst_q <= XCC_XS_RUN;
          end
        end
        default: xst_q <= XCC_XS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (xst_q != XCC_XS_START && xst_q != XCC_XS_FAIL) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(RESET_TO_CYC)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_req_o <= 1'b0;
      reset_done_q    <= 1'b0;
    end else begin
      sys_reset_req_o <= 1'b0;
      if (xst_q != XCC_XS_START && xst_q != XCC_XS_FAIL) begin
        reset_done_q <= 1'b0;
      end else if (inhibit_q && !reset_done_q &&
                   cnt_q == CW'(RESET_TO_CYC)) begin
        sys_reset_req_o <= 1'b1;
        reset_done_q    <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_hold_o <= 1'b0;
    end else begin
      on_hold_o <= inhibit_q & ~verified;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags, set wins over clear

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_flag_q  <= 1'b0;
      tamper_flag_q <= 1'b0;
    end else begin
      if (fail_ev) begin
        start_flag_q <= 1'b1;
      end else if (wr && idx == `XCC_IDX_IRQ_FLAGS && wb_sel_i[0] &&
                   wb_dat_i[`XCC_B_START_FAIL]) begin
        start_flag_q <= 1'b0;
      end
      if (tamper_ev) begin
        tamper_flag_q <= 1'b1;
      end else if (wr && idx == `XCC_IDX_IRQ_FLAGS && wb_sel_i[0] &&
                   wb_dat_i[`XCC_B_TAMPER]) begin
        tamper_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rtc_osc_primary_irq_o <= 1'b0;
    end else begin
      rtc_osc_primary_irq_o <= (start_flag_q & ~start_mask_q) |
                               tamper_flag_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock output pin

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_live_q <= 1'b0;
    end else begin
      out_live_q <= out_en_q && pwr_state_i != XCC_PS_OFF &&
                    !(inhibit_q && !verified);
    end
  end

  xcc_clk_switch u_switch (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .sel_xtal_i (verified),
    .xtal_lvl_i (xtal_clk_i),
    .rc_lvl_i   (rc_clk_i),
    .en_i       (out_live_q),
    .od_i       (out_od_q),
    .pin_o      (clock_output_pin_o),
    .oe_o       (clock_output_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_verified_off;
    !osc_run_o |=> !verified;
  endproperty
  a_verified_off: assert property (p_verified_off)
    else $error("verified while oscillator off");

  property p_key_lock;
    wr && idx == `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL && !user_key_unlocked_i &&
      !seq_on_hit && !seq_off_hit |=> $stable(out_en_q);
  endproperty
  a_key_lock: assert property (p_key_lock)
    else $error("output enable changed while key locked");

  property p_on_slot;
    seq_up_i && on_slot_q == `XCC_SLOT_MIN && timeslot_i == `XCC_SLOT_MIN |=> out_en_q;
  endproperty
  a_on_slot: assert property (p_on_slot)
    else $error("output not enabled in its slot");

  property p_hold;
    inhibit_q && xst_q == XCC_XS_START |=> on_hold_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("on transition not held");

  property p_osc_ro;
    !cfg_load_i |=> $stable(osc_en_q);
  endproperty
  a_osc_ro: assert property (p_osc_ro)
    else $error("oscillator enable changed without load");

  property p_backup;
    pwr_state_i == XCC_PS_BACKUP && !backup_en_q |=> !rtc_clk_en_o;
  endproperty
  a_backup: assert property (p_backup)
    else $error("rtc clocked in backup without enable");

  property p_fail_flag;
    $rose(xst_q == XCC_XS_FAIL) |-> start_flag_q;
  endproperty
  a_fail_flag: assert property (p_fail_flag)
    else $error("start failure flag not set");

  property p_tamper;
    xst_q == XCC_XS_RUN && osc_run_o && !xtal_running_i |=>
      tamper_flag_q ##1 rtc_osc_primary_irq_o;
  endproperty
  a_tamper: assert property (p_tamper)
    else $error("tamper not flagged or not signalled");

  property p_mask;
    start_mask_q && !tamper_flag_q |=> !rtc_osc_primary_irq_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked event reached interrupt");

  property p_off_pin;
    (pwr_state_i == XCC_PS_OFF) [*2] |=>
      !clock_output_oe_o && !clock_output_pin_o;
  endproperty
  a_off_pin: assert property (p_off_pin)
    else $error("clock output active in off state");

  c_fail:    cover property ($rose(start_flag_q));
  c_tamper:  cover property ($rose(tamper_flag_q));
  c_reset:   cover property (sys_reset_req_o);
  c_switch:  cover property ($rose(verified) ##[1:20] clock_output_pin_o);
endmodule

`default_nettype wire

// file: testbench/crystal_clock_output_pin_control_bench.sv
/*
 * Self-checking bench for the crystal supervision and clock output block.
 * Assumes xcc_top with shortened timeouts and its classic Wishbone slave.
 */
`timescale 1ns/1ps
`default_nettype none
`include "xcc_regs.svh"

module crystal_clock_output_pin_control_bench;
  import xcc_pkg::*;
  localparam int SF = 20;
  localparam int RT = 40;
  logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0]       wb_adr_i, wb_dat_i, wb_dat_o, lfsr, exp_q[$];
  logic [3:0]        wb_sel_i;
  logic [2:0]        timeslot_i;
  logic [1:0]        tick;
  xcc_pwr_t          pwr_state_i;
  logic              seq_up_i, seq_sleep_i, user_key_unlocked_i, cfg_load_i, cfg_osc_enable_i;
  logic              xtal_running_i, xtal_clk_i, rc_clk_i, osc_run_o, rtc_clk_en_o, on_hold_o;
  logic              sys_reset_req_o, irq, pin, oe, p0;
  int                n_errors, checked, n_rst;

  xcc_top #(.START_FAIL_CYC(SF), .RESET_TO_CYC(RT)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwr_state_i(pwr_state_i),
    .seq_up_i(seq_up_i), .seq_sleep_i(seq_sleep_i), .timeslot_i(timeslot_i),
    .user_key_unlocked_i(user_key_unlocked_i), .cfg_load_i(cfg_load_i),
    .cfg_osc_enable_i(cfg_osc_enable_i), .xtal_running_i(xtal_running_i),
    .xtal_clk_i(xtal_clk_i), .rc_clk_i(rc_clk_i), .osc_run_o(osc_run_o),
    .rtc_clk_en_o(rtc_clk_en_o), .on_hold_o(on_hold_o), .sys_reset_req_o(sys_reset_req_o),
    .rtc_osc_primary_irq_o(irq), .clock_output_pin_o(pin), .clock_output_oe_o(oe));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    check("pending reads", 32'(exp_q.size()), 32'h0000_0000);
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {14'h0000, idx, 2'b00};
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    exp_q.push_back({16'h0000, exp});
    bus(1'b0, idx, 16'h0000);
  endtask

  // one sequence timeslot, either the wanted one or a random one
  task automatic slot(input logic sleep, input logic [2:0] c);
    logic [2:0] tgt;
    logic [2:0] ts;
    logic       ok;
    lfsr = lfsr_next(lfsr);
    tgt = sleep ? 3'(6 - c) : c;
    ts = lfsr[0] ? tgt : 3'(lfsr[8:1] % 5 + 1);
    ok = (c >= 3'h1) && (c <= 3'h5) && (ts == tgt);
    bus(1'b1, `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, sleep ? {1'b1, 8'h00, c, 4'h0} : {5'h00, c, 8'h00});
    seq_up_i    <= ~sleep;
    seq_sleep_i <= sleep;
    timeslot_i  <= ts;
    cyc(3);
    seq_up_i    <= 1'b0;
    seq_sleep_i <= 1'b0;
    rd(`XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, sleep ? {~ok, 8'h00, c, 4'h0} : {ok, 4'h0, c, 8'h00});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (rst_i === 1'b1) begin
      {rc_clk_i, xtal_clk_i, tick} <= '0;
    end else begin
      rc_clk_i   <= ~rc_clk_i;
      tick       <= tick + 2'd1;
      xtal_clk_i <= tick[1];
    end
    if (sys_reset_req_o === 1'b1) n_rst++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h0000_0001, 32'h0000_0000);
      else check("read data", wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    cyc(5000);
    n_errors++;
    end_of_test();
  end

  initial begin
    {rst_i, wb_sel_i, lfsr} = {1'b1, 4'b0011, 32'h24be_472e};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {seq_up_i, seq_sleep_i, timeslot_i, user_key_unlocked_i, cfg_load_i} = '0;
    {cfg_osc_enable_i, xtal_running_i} = '0;
    pwr_state_i = XCC_PS_ON;
    cyc(3);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'h0000);
    rd(`XCC_IDX_OSC_CTRL, 16'h1000);
    rd(`XCC_IDX_IRQ_MASKS, 16'h0080);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0000);
    rd(`XCC_IDX_SYS_STATE, 16'h0000);
    rd(16'h0123, 16'h0000);
    $display("test reset values done");
    bus(1'b1, `XCC_IDX_OSC_CTRL, 16'hffff);
    rd(`XCC_IDX_OSC_CTRL, 16'h9000);
    cfg_osc_enable_i <= 1'b1;
    cfg_load_i       <= 1'b1;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
    cyc(SF + 10);
    rd(`XCC_IDX_OSC_CTRL, 16'hb000);
    check("osc run", osc_run_o, 1'b1);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0080);
    check("masked irq", irq, 1'b0);
    bus(1'b1, `XCC_IDX_IRQ_MASKS, 16'h0000);
    cyc(2);
    check("unmasked irq", irq, 1'b1);
    bus(1'b1, `XCC_IDX_IRQ_FLAGS, 16'h0000);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0080);
    bus(1'b1, `XCC_IDX_IRQ_FLAGS, 16'h0080);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0000);
    check("cleared irq", irq, 1'b0);
    cyc(RT);
    check("reset requests", n_rst, 1);
    $display("test start failure done");
    xtal_running_i <= 1'b1;
    cyc(3);
    rd(`XCC_IDX_SYS_STATE, 16'h0080);
    check("on hold", on_hold_o, 1'b0);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0000);
    xtal_running_i <= 1'b0;
    cyc(3);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0040);
    rd(`XCC_IDX_SYS_STATE, 16'h0000);
    bus(1'b1, `XCC_IDX_IRQ_FLAGS, 16'h0040);
    xtal_running_i <= 1'b1;
    cyc(3);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0040);
    check("tamper irq", irq, 1'b1);
    bus(1'b1, `XCC_IDX_IRQ_FLAGS, 16'h0040);
    rd(`XCC_IDX_IRQ_FLAGS, 16'h0000);
    $display("test tamper done");
    pwr_state_i <= XCC_PS_SLEEP;
    cyc(3);
    check("sleep osc run", osc_run_o, 1'b1);
    pwr_state_i <= XCC_PS_BACKUP;
    cyc(3);
    check("backup rtc clock", rtc_clk_en_o, 1'b1);
    bus(1'b1, `XCC_IDX_OSC_CTRL, 16'h8000);
    cyc(3);
    check("backup rtc off", rtc_clk_en_o, 1'b0);
    check("backup osc off", osc_run_o, 1'b0);
    pwr_state_i <= XCC_PS_ON;
    $display("test backup done");
    bus(1'b1, `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'h8000);
    rd(`XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'h0000);
    user_key_unlocked_i <= 1'b1;
    bus(1'b1, `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'h8000);
    rd(`XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'h8000);
    cyc(4);
    check("cmos drive", oe, 1'b1);
    pwr_state_i <= XCC_PS_OFF;
    cyc(4);
    check("off state drive", oe, 1'b0);
    pwr_state_i <= XCC_PS_ON;
    bus(1'b1, `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'ha000);
    cyc(4);
    check("open drain data", pin, 1'b0);
    bus(1'b1, `XCC_IDX_OSC_CTRL, 16'h0000);
    bus(1'b1, `XCC_IDX_CLOCK_OUTPUT_PIN_CTRL, 16'h8000);
    xtal_running_i <= 1'b0;
    cyc(8);
    p0 = pin;
    @(posedge clk_i);
    check("rc source", pin ^ p0, 1'b1);
    @(posedge clk_i);
    check("rc source", pin ^ p0, 1'b0);
    $display("test clock output done");
    for (int c = 0; c < 8; c++) begin
      slot(1'b0, 3'(c));
      slot(1'b1, 3'(c));
    end
    $display("test timeslots done");
    end_of_test();
  end
endmodule
`default_nettype wire
